/* File: ocf_defs.vh */
// Constants for the fast overcurrent fault response controller.
// Assumes inclusion by bare name from the design files only.
`ifndef OCF_DEFS_VH
`define OCF_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (command codes)
// ----------------------------------------------------------------
`define OCF_FAULT_CFG_OFFSET     8'hC8
`define OCF_ACTION_OFFSET        8'hCA

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCF_MODE_HI              7
`define OCF_MODE_LO              6
`define OCF_RETRY_HI             5
`define OCF_RETRY_LO             3
`define OCF_DELAY_HI             2
`define OCF_DELAY_LO             0
`define OCF_UNIT_HI              3
`define OCF_UNIT_LO              2

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define OCF_MODE_IGNORE          2'h0
`define OCF_MODE_RETRY           2'h3
`define OCF_RETRY_NONE           3'h0
`define OCF_RETRY_FOREVER        3'h7
`define OCF_ACTION_RESET         8'h00
`define OCF_FAULT_CFG_RESET      8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OCF_CLK_MHZ              125
`define OCF_UNIT_MS              1
`define OCF_CYC_PER_MS           (`OCF_UNIT_MS * `OCF_CLK_MHZ * 1000)

`endif

/* File: ocf_tick_gen.v */
// Time-unit tick generator: one pulse per selected delay unit.
// Assumes a free-running system clock and a restart request.
`timescale 1ns/100ps
`include "ocf_defs.vh"

module ocf_tick_gen
#(
    parameter CYC_PER_MS = `OCF_CYC_PER_MS
)
(
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire       restart,   // Realign the unit on timer start
    input  wire [1:0] unit_sel,  // 1, 4, 16 or 256 ms per unit
    output reg        tick_ff    // One-cycle pulse per unit
);

    // ------------------------------------------------------------
    // Millisecond prescaler and unit counter
    // ------------------------------------------------------------
    reg  [31:0] ms_cnt_ff;       // Cycles within one ms
    reg  [7:0]  unit_cnt_ff;     // Whole ms within one unit
    reg  [7:0]  unit_last;       // Terminal ms count
    wire        ms_end;

    assign ms_end = (ms_cnt_ff == CYC_PER_MS - 1);

    // Unit length selection
    always @*
    begin
        case (unit_sel)
            2'h0:    unit_last = 8'h00;
            2'h1:    unit_last = 8'h03;
            2'h2:    unit_last = 8'h0F;
            default: unit_last = 8'hFF;
        endcase
    end

    // Counters; restart keeps the first unit a full unit long
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ms_cnt_ff   <= 32'h0;
            unit_cnt_ff <= 8'h00;
            tick_ff     <= 1'b0;
        end
        else if (restart)
        begin
            ms_cnt_ff   <= 32'h0;
            unit_cnt_ff <= 8'h00;
            tick_ff     <= 1'b0;
        end
        else
        begin
            tick_ff <= 1'b0;
            if (ms_end)
            begin
                ms_cnt_ff <= 32'h0;
                if (unit_cnt_ff >= unit_last)
                begin
                    unit_cnt_ff <= 8'h00;
                    tick_ff     <= 1'b1;
                end
                else
                    unit_cnt_ff <= unit_cnt_ff + 8'h01;
            end
            else
                ms_cnt_ff <= ms_cnt_ff + 32'h1;
        end
    end

endmodule

/* File: ocf_retry_ctrl.v */
// Fast overcurrent fault response controller with retry sequencing.
// Assumes a synchronous register write port and asynchronous fault pins.
`timescale 1ns/100ps
`include "ocf_defs.vh"

// Notes on behaviour
// - Any mode: set status bit, notify host
// - Mode 00: constant-current limiting forever
// - Mode 11: limit for delay, then retry
// - Retry 000: stay disabled until cleared
// - Retry 1..6: that many attempts, then off
// - Attempts spaced by delay times unit
// - Retry 111: retry until commanded off
// - Delay field means two-to-the-field units
// - Unit length from fault config register
// - Unit field: 1, 4, 16, 256 ms
module overcurrent_fault_retry_ctrl
#(
    parameter CYC_PER_MS = `OCF_CYC_PER_MS
)
(
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire       reg_wr,           // Register write strobe
    input  wire [7:0] reg_addr,         // Command code
    input  wire [7:0] reg_wdata,        // Write data
    output reg  [7:0] reg_rdata_ff,     // Read data for reg_addr
    input  wire       fast_fault_pin,   // Fast overcurrent comparator
    input  wire       limiting_pin,     // Output still in current limit
    input  wire       run_cmd,          // Control pin / operation on
    input  wire       other_fault,      // Another fault shut us down
    input  wire       clear_fault,      // Fault clear pulse
    output reg        fault_status_ff,  // Sticky status bit
    output reg        host_alert_ff,    // Host notification level
    output reg        cc_limit_ff,      // Hold at current_limit_setpoint
    output reg        fast_limit_ff,    // Hold at fast_current_limit_setpoint
    output reg        output_en_ff,     // Power stage enable
    output reg  [2:0] attempts_ff       // Restart attempts made
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [4:0] S_RUN     = 5'h01; // Normal regulation
    localparam [4:0] S_CC      = 5'h02; // Constant-current forever
    localparam [4:0] S_LIMIT   = 5'h04; // Fast limiting for delay
    localparam [4:0] S_WAIT    = 5'h08; // Off, waiting to retry
    localparam [4:0] S_LATCHED = 5'h10; // Off until cleared

    // ------------------------------------------------------------
    // Input synchronisers (two flops each)
    // ------------------------------------------------------------
    reg  [2:0] sync1_ff;                // First stage, read only below
    reg  [2:0] sync2_ff;                // Second stage
    wire       fault_s;
    wire       limit_s;
    wire       run_s;

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end
        else
        begin
            sync1_ff <= {run_cmd, limiting_pin, fast_fault_pin};
            sync2_ff <= sync1_ff;
        end
    end

    assign fault_s = sync2_ff[0];
    assign limit_s = sync2_ff[1];
    assign run_s   = sync2_ff[2];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] action_ff;               // fast_overcurrent_fault_action
    reg  [7:0] fault_cfg_ff;            // Fault config, unit fields

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            action_ff    <= `OCF_ACTION_RESET;
            fault_cfg_ff <= `OCF_FAULT_CFG_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `OCF_ACTION_OFFSET)
                action_ff <= reg_wdata;
            if (reg_addr == `OCF_FAULT_CFG_OFFSET)
                fault_cfg_ff <= reg_wdata;
        end
    end

    // Read mux; unmapped codes read zero
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            reg_rdata_ff <= 8'h00;
        else if (reg_addr == `OCF_ACTION_OFFSET)
            reg_rdata_ff <= action_ff;
        else if (reg_addr == `OCF_FAULT_CFG_OFFSET)
            reg_rdata_ff <= fault_cfg_ff;
        else
            reg_rdata_ff <= 8'h00;
    end

    wire [1:0] mode  = action_ff[`OCF_MODE_HI:`OCF_MODE_LO];
    wire [2:0] retry = action_ff[`OCF_RETRY_HI:`OCF_RETRY_LO];
    wire [2:0] dly   = action_ff[`OCF_DELAY_HI:`OCF_DELAY_LO];

    // ------------------------------------------------------------
    // Delay timer in units
    // ------------------------------------------------------------
    reg  [4:0] state_ff;
    reg  [4:0] nxt_state;
    reg  [7:0] unit_cnt_ff;             // Units elapsed
    reg        timer_start;
    wire       tick;
    wire [7:0] dly_units;
    wire       dly_done;
    wire       stop;

    assign dly_units = 8'h01 << dly;
    assign dly_done  = tick && (unit_cnt_ff + 8'h01 >= dly_units);
    // Command off or another fault ends any sequence
    assign stop      = !run_s || other_fault;

    ocf_tick_gen #(.CYC_PER_MS(CYC_PER_MS)) u_tick
    (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .restart  (timer_start),
        .unit_sel (fault_cfg_ff[`OCF_UNIT_HI:`OCF_UNIT_LO]),
        .tick_ff  (tick)
    );

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            unit_cnt_ff <= 8'h00;
        else if (timer_start)
            unit_cnt_ff <= 8'h00;
        else if (tick)
            unit_cnt_ff <= unit_cnt_ff + 8'h01;
    end

    // ------------------------------------------------------------
    // Response state machine
    // ------------------------------------------------------------
    always @*
    begin
        nxt_state   = state_ff;
        timer_start = 1'b0;
        case (state_ff)
            S_RUN:
            begin
                // No fast limiting while commanded off or another fault holds us off
                if (fault_s && !stop)
                begin
                    timer_start = 1'b1;
                    if (mode == `OCF_MODE_IGNORE)
                        nxt_state = S_CC;
                    else if (mode == `OCF_MODE_RETRY)
                        nxt_state = S_LIMIT;
                end
            end
            S_CC:
            begin
                // Stays limiting until current falls or output off
                if (stop || !fault_s)
                    nxt_state = S_RUN;
            end
            S_LIMIT:
            begin
                if (stop)
                    nxt_state = S_RUN;
                else if (dly_done)
                begin
                    timer_start = 1'b1;
                    if (!limit_s)
                        nxt_state = S_RUN;
                    else if (retry == `OCF_RETRY_NONE)
                        nxt_state = S_LATCHED;
                    else if (retry != `OCF_RETRY_FOREVER &&
                             attempts_ff >= retry)
                        nxt_state = S_LATCHED;
                    else
                        nxt_state = S_WAIT;
                end
            end
            S_WAIT:
            begin
                // Restart after one delay period
                if (stop)
                    nxt_state = S_RUN;
                else if (dly_done)
                begin
                    timer_start = 1'b1;
                    nxt_state   = S_LIMIT;
                end
            end
            S_LATCHED:
            begin
                if (clear_fault || stop)
                    nxt_state = S_RUN;
            end
            default:
                nxt_state = S_RUN;
        endcase
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff    <= S_RUN;
            attempts_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state == S_RUN || state_ff == S_RUN)
                attempts_ff <= 3'h0;
            else if (state_ff == S_WAIT && nxt_state == S_LIMIT &&
                     attempts_ff != 3'h7)
                attempts_ff <= attempts_ff + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Outputs, status and notification
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            fault_status_ff <= 1'b0;
            host_alert_ff   <= 1'b0;
            cc_limit_ff     <= 1'b0;
            fast_limit_ff   <= 1'b0;
            output_en_ff    <= 1'b0;
        end
        else
        begin
            // Set wins over a clear in the same cycle
            if (fault_s)
            begin
                fault_status_ff <= 1'b1;
                host_alert_ff   <= 1'b1;
            end
            else if (clear_fault)
            begin
                fault_status_ff <= 1'b0;
                host_alert_ff   <= 1'b0;
            end
            cc_limit_ff   <= (nxt_state == S_CC);
            fast_limit_ff <= (nxt_state == S_LIMIT);
            output_en_ff  <= run_s && !other_fault &&
                             (nxt_state != S_WAIT) &&
                             (nxt_state != S_LATCHED);
        end
    end

endmodule

/* File: ocf_retry_sva.sv */
// Checker for the fast overcurrent fault retry controller.
// Assumes binding to the controller top and a 4-state simulator.
`timescale 1ns/100ps
module ocf_retry_sva
#(
    parameter CYC_PER_MS = 10
)
(
    input wire       clk_sys,
    input wire       rstn,
    input wire       reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_ff,
    input wire       fast_fault_pin,
    input wire       limiting_pin,
    input wire       run_cmd,
    input wire       other_fault,
    input wire       clear_fault,
    input wire       fault_status_ff,
    input wire       host_alert_ff,
    input wire       cc_limit_ff,
    input wire       fast_limit_ff,
    input wire       output_en_ff,
    input wire [2:0] attempts_ff
);
    // ------------------------------------------------
    // Shadow registers and off-time counter
    // ------------------------------------------------
    reg  [7:0]  act_ff;  // Copy of the action setting
    reg  [1:0]  unit_ff; // Copy of the unit field
    reg  [31:0] off_ff;  // Cycles with the output off
    wire [31:0] mul = unit_ff == 2'h3 ? 256 : 32'h1 << (2 * unit_ff);
    wire [31:0] dly = (CYC_PER_MS * mul) << act_ff[2:0];

    // Track writes the same way the register file does
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            act_ff <= 8'h00;
            unit_ff <= 2'h0;
            off_ff <= 32'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'hCA)
                act_ff <= reg_wdata;
            if (reg_wr && reg_addr == 8'hC8)
                unit_ff <= reg_wdata[3:2];
            off_ff <= output_en_ff ? 32'h0 : off_ff + 32'h1;
        end
    end

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence fault_seen;
        (fast_fault_pin && run_cmd && output_en_ff) [*3];
    endsequence
    sequence wr_held;
        reg_wr && reg_addr == 8'hCA ##1 reg_addr == 8'hCA;
    endsequence

    alert_match_a: assert property (fault_status_ff == host_alert_ff)
        else $error("alert differs from status");
    fault_flag_a: assert property (fault_seen |-> ##[0:3] fault_status_ff)
        else $error("fault not flagged");
    cc_mode_a: assert property (cc_limit_ff |-> act_ff[7:6] == 2'h0 && output_en_ff)
        else $error("constant current outside mode 00");
    fast_mode_a: assert property (fast_limit_ff |-> act_ff[7:6] == 2'h3 && output_en_ff)
        else $error("fast limit outside mode 11");
    retry_cap_a: assert property (act_ff[5:3] != 3'h7 |-> attempts_ff <= act_ff[5:3])
        else $error("too many restart attempts");
    attempt_step_a: assert property (attempts_ff != $past(attempts_ff)
        |-> attempts_ff == $past(attempts_ff) + 3'h1 || attempts_ff == 3'h0)
        else $error("attempt count jumped");
    retry_gap_a: assert property ($rose(output_en_ff) && fault_status_ff && act_ff[7:6] == 2'h3
        |-> $past(off_ff) + 2 >= dly && $past(off_ff) <= dly + 4)
        else $error("restart spacing wrong");
    cmd_off_a: assert property (!run_cmd [*5] |-> !output_en_ff && attempts_ff == 3'h0)
        else $error("output not off on command");
    other_off_a: assert property (other_fault |-> ##2 attempts_ff == 3'h0)
        else $error("attempts kept after other fault");
    read_back_a: assert property (wr_held |=> reg_rdata_ff == $past(reg_wdata, 2))
        else $error("action register read back wrong");
endmodule

bind overcurrent_fault_retry_ctrl ocf_retry_sva #(.CYC_PER_MS(CYC_PER_MS)) i_ocf_retry_sva (.*);

/* File: power_stage_model.sv */
// Output stage and load seen by the controller.
// Assumes current flows only while the stage is enabled.
`timescale 1ns/100ps
module power_stage_model
(
    input  wire  output_en_ff, // Stage enable from controller
    input  wire  overload,     // Bench-chosen short on output
    output logic fast_fault_pin,
    output logic limiting_pin
);
    // Both flags drop at once when the stage is off
    assign fast_fault_pin = overload && output_en_ff;
    assign limiting_pin   = overload && output_en_ff;
endmodule

/* File: overcurrent_fault_retry_ctrl_bench.sv */
// Self-checking bench for the fault retry controller.
// Assumes a short time unit of 10 clocks per ms.
`timescale 1ns/100ps
module overcurrent_fault_retry_ctrl_bench;
    logic       clk_sys, rstn, reg_wr, run_cmd, other_fault, clear_fault, overload;
    logic [7:0] reg_addr, reg_wdata;
    wire  [7:0] reg_rdata_ff;
    wire        fast_fault_pin, limiting_pin, fault_status_ff, host_alert_ff;
    wire        cc_limit_ff, fast_limit_ff, output_en_ff;
    wire  [2:0] attempts_ff;
    int         mismatches = 0;
    int         compares = 0;
    int         n, e, d;
    int         mul[4] = '{1, 4, 16, 256};

    overcurrent_fault_retry_ctrl #(.CYC_PER_MS(10)) i_overcurrent_fault_retry_ctrl (.*);
    power_stage_model i_power_stage_model (.*);

    always #4 clk_sys = ~clk_sys;

    // ------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------
    task check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task check_in(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        reg_addr = a;
        repeat (2) @(negedge clk_sys);
        check(reg_rdata_ff, v);
    endtask
    // Bounded wait: 0 output enable, 1 fast limit, 2 status
    task wait_on(input int s, input logic v);
        n = 0;
        while ((s == 0 ? output_en_ff : s == 1 ? fast_limit_ff : fault_status_ff) !== v
               && n < 6000)
        begin
            @(negedge clk_sys);
            n++;
        end
        // A wait that runs out is a failure in its own right
        if (n >= 6000)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, !v, v);
        end
    endtask
    // Remove load, let the synchronisers settle, then clear
    task clr;
        overload = 1'b0;
        repeat (5) @(negedge clk_sys);
        clear_fault = 1'b1;
        @(negedge clk_sys);
        clear_fault = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the longest delay sequence
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        end_of_test;
    end

    // ------------------------------------------------
    // Test sequence
    // ------------------------------------------------
    initial
    begin
        {clk_sys, rstn, reg_wr, other_fault, clear_fault, overload} = 6'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        run_cmd = 1'b1;
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        rd(8'hCA, 8'h00);
        rd(8'hC8, 8'h00);
        wr(8'h55, 8'hA5);
        rd(8'h55, 8'h00);
        wr(8'hCA, 8'h00);
        overload = 1'b1;
        wait_on(2, 1'b1);
        check_in(n, 1, 5);
        repeat (300) @(negedge clk_sys);
        check({host_alert_ff, cc_limit_ff, fast_limit_ff, output_en_ff}, 8'h0D);
        clr;
        check(fault_status_ff, 1'b0);
        // Mode 01: only status and alert, output keeps running unlimited
        wr(8'hCA, 8'h40);
        overload = 1'b1;
        repeat (20) @(negedge clk_sys);
        check({host_alert_ff, cc_limit_ff, fast_limit_ff, output_en_ff}, 8'h09);
        clr;
        // Each unit with a different delay, no retry
        for (int u = 0; u < 4; u++)
        begin
            d = u == 0 ? 7 : 3 - u;
            e = (10 * mul[u]) << d;
            wr(8'hC8, {4'h0, u[1:0], 2'h3});
            wr(8'hCA, {5'h18, d[2:0]});
            rd(8'hCA, {5'h18, d[2:0]});
            overload = 1'b1;
            wait_on(1, 1'b1);
            wait_on(0, 1'b0);
            check_in(n, e - 2, e + 4);
            repeat (50) @(negedge clk_sys);
            check({output_en_ff, attempts_ff}, 8'h00);
            clr;
            check(output_en_ff, 1'b1);
        end
        wr(8'hC8, 8'h00);
        wr(8'hCA, 8'hD0);
        overload = 1'b1;
        wait_on(1, 1'b1);
        wait_on(0, 1'b0);
        wait_on(0, 1'b1);
        check_in(n, 8, 14);
        repeat (200) @(negedge clk_sys);
        check({output_en_ff, attempts_ff}, 8'h02);
        clr;
        wr(8'hCA, 8'hF8);
        overload = 1'b1;
        repeat (300) @(negedge clk_sys);
        // Align to a restart first so the off time is measured whole
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
        wait_on(0, 1'b1);
        check_in(n, 8, 14);
        // Another fault turns the output off; command off keeps it off after it clears
        other_fault = 1'b1;
        repeat (2) @(negedge clk_sys);
        check({fast_limit_ff, output_en_ff, attempts_ff}, 8'h00);
        run_cmd = 1'b0;
        repeat (8) @(negedge clk_sys);
        other_fault = 1'b0;
        repeat (2) @(negedge clk_sys);
        check({output_en_ff, attempts_ff}, 8'h00);
        clr;
        run_cmd = 1'b1;
        repeat (8) @(negedge clk_sys);
        check(output_en_ff, 1'b1);
        end_of_test;
    end
endmodule
